// *** hw/dtx_regs.vh ***
// Constants of the data transfer execution unit
// What this block does
// - The timer read copies the full 16-bit timer count into the addressed RAM word and leaves every flag alone.
// - The timer write loads the 16-bit timer from the addressed RAM word and changes no flag.
// - The exchange swaps the accumulator and the addressed byte in one operation with all flags unchanged.
// - The pop first lowers the stack pointer by 2, then restores accumulator and all four flags from the two bytes there.
// - The push stores flags and accumulator at the stack pointer, then raises it by 2, changing no flag.
// - The indirect store writes the accumulator to the byte a RAM byte pointer names, in two cycles, flags kept.
// - The indirect load reads the byte a RAM byte pointer names into the accumulator, in three cycles, flags kept.
`ifndef DTX_REGS_VH
`define DTX_REGS_VH

// Operation codes on op_code
`define DTX_OP_TMR_READ 3'h0
`define DTX_OP_TMR_WRITE 3'h1
`define DTX_OP_EXCHANGE 3'h2
`define DTX_OP_POP 3'h3
`define DTX_OP_PUSH 3'h4
`define DTX_OP_IND_STORE 3'h5
`define DTX_OP_IND_LOAD 3'h6

// Flag bit positions inside the flag byte
`define DTX_FLAG_Z 0
`define DTX_FLAG_C 1
`define DTX_FLAG_AC 2
`define DTX_FLAG_OV 3

// Reset values
`define DTX_ACC_RESET 8'h00
`define DTX_FLAG_RESET 4'h0
`define DTX_SP_RESET 8'h00

// Stack pointer step per push or pop
`define DTX_SP_STEP 8'h02

`endif

// *** hw/dtx_stack_ptr.v ***
// Stack pointer register with load and step by two
`timescale 1ns/1ps
`include "dtx_regs.vh"

module dtx_stack_ptr (
	input wire core_clk,
	input wire rst,
	input wire load,
	input wire [7:0] load_val,
	input wire step_up,
	input wire step_down,
	output reg [7:0] sp
);

always @(posedge core_clk) begin
	if (rst) begin
		sp <= `DTX_SP_RESET;
	end else if (step_down) begin
		sp <= sp - `DTX_SP_STEP;
	end else if (step_up) begin
		sp <= sp + `DTX_SP_STEP;
	end else if (load) begin
		sp <= load_val;
	end
end

endmodule // dtx_stack_ptr

// *** hw/dtx_exec_unit.v ***
// Execution unit for timer, exchange, stack and indirect transfers
`timescale 1ns/1ps
`include "dtx_regs.vh"

module dtx_exec_unit (
	input wire core_clk,
	input wire rst,
	input wire op_valid,
	input wire [2:0] op_code,
	input wire [7:0] op_addr,
	input wire ext_acc_wr,
	input wire [7:0] ext_acc_val,
	input wire ext_flag_wr,
	input wire [3:0] ext_flag_val,
	input wire ext_sp_wr,
	input wire [7:0] ext_sp_val,
	input wire [7:0] mem_rd_data,
	input wire [15:0] timer_count,
	output reg busy,
	output reg op_done,
	output reg [7:0] acc,
	output reg [3:0] flags,
	output wire [7:0] sp,
	output reg [7:0] mem_addr,
	output reg mem_wr_en,
	output reg [7:0] mem_wr_data,
	output reg mem_rd_en,
	output reg timer_load,
	output reg [15:0] timer_load_val
);

localparam ST_IDLE = 3'h0;
localparam ST_WRITE_HI = 3'h1;
localparam ST_READ_HI = 3'h2;
localparam ST_READ_FIN = 3'h3;
localparam ST_READ_ONE = 3'h4;
localparam ST_READ_LAST = 3'h5;

reg [2:0] state;
reg [2:0] op;
reg [7:0] base;
reg [15:0] cap;
reg [7:0] lo_byte;
reg sp_up;
reg sp_down;
wire accept;
wire idle_ext;
wire [7:0] sp_now;
wire [7:0] sp_less;
wire [7:0] base_next;

assign accept = (state == ST_IDLE) && op_valid;
assign idle_ext = (state == ST_IDLE) && !op_valid;
// Push step may still be pending when the next op is taken
assign sp_now = sp_up ? sp + `DTX_SP_STEP : sp;
assign sp_less = sp_now - `DTX_SP_STEP;
assign base_next = base + 8'h01;

////////////////////////////////////////////////////////////////////////
// Stack pointer

dtx_stack_ptr u_sp (
	.core_clk(core_clk),
	.rst(rst),
	.load(ext_sp_wr && idle_ext),
	.load_val(ext_sp_val),
	.step_up(sp_up),
	.step_down(sp_down),
	.sp(sp)
);

////////////////////////////////////////////////////////////////////////
// Sequencer

always @(posedge core_clk) begin
	if (rst) begin
		state <= ST_IDLE;
		op <= 3'h0;
		base <= 8'h00;
		cap <= 16'h0000;
		lo_byte <= 8'h00;
		busy <= 1'b0;
		op_done <= 1'b0;
		acc <= `DTX_ACC_RESET;
		flags <= `DTX_FLAG_RESET;
		mem_addr <= 8'h00;
		mem_wr_en <= 1'b0;
		mem_wr_data <= 8'h00;
		mem_rd_en <= 1'b0;
		timer_load <= 1'b0;
		timer_load_val <= 16'h0000;
		sp_up <= 1'b0;
		sp_down <= 1'b0;
	end else begin
		op_done <= 1'b0;
		mem_wr_en <= 1'b0;
		mem_rd_en <= 1'b0;
		timer_load <= 1'b0;
		sp_up <= 1'b0;
		sp_down <= 1'b0;
		case (state)
		ST_IDLE: begin
			if (ext_acc_wr && idle_ext) begin
				acc <= ext_acc_val;
			end
			if (ext_flag_wr && idle_ext) begin
				flags <= ext_flag_val;
			end
			if (accept) begin
				op <= op_code;
				base <= op_addr;
				busy <= 1'b1;
				case (op_code)
				`DTX_OP_TMR_READ: begin
					cap <= timer_count;
					mem_addr <= op_addr;
					mem_wr_data <= timer_count[7:0];
					mem_wr_en <= 1'b1;
					state <= ST_WRITE_HI;
				end
				`DTX_OP_TMR_WRITE: begin
					mem_addr <= op_addr;
					mem_rd_en <= 1'b1;
					state <= ST_READ_HI;
				end
				`DTX_OP_POP: begin
					sp_down <= 1'b1;
					base <= sp_less;
					mem_addr <= sp_less;
					mem_rd_en <= 1'b1;
					state <= ST_READ_HI;
				end
				`DTX_OP_PUSH: begin
					cap <= {4'h0, flags, acc};
					base <= sp_now;
					mem_addr <= sp_now;
					mem_wr_data <= acc;
					mem_wr_en <= 1'b1;
					state <= ST_WRITE_HI;
				end
				`DTX_OP_EXCHANGE, `DTX_OP_IND_STORE,
				`DTX_OP_IND_LOAD: begin
					mem_addr <= op_addr;
					mem_rd_en <= 1'b1;
					state <= ST_READ_ONE;
				end
				default: begin
					// Unused code completes at once
					busy <= 1'b0;
					op_done <= 1'b1;
				end
				endcase
			end
		end
		ST_WRITE_HI: begin
			mem_addr <= base_next;
			mem_wr_data <= cap[15:8];
			mem_wr_en <= 1'b1;
			if (op == `DTX_OP_PUSH) begin
				sp_up <= 1'b1;
			end
			busy <= 1'b0;
			op_done <= 1'b1;
			state <= ST_IDLE;
		end
		ST_READ_HI: begin
			lo_byte <= mem_rd_data;
			mem_addr <= base_next;
			mem_rd_en <= 1'b1;
			state <= ST_READ_FIN;
		end
		ST_READ_FIN: begin
			if (op == `DTX_OP_TMR_WRITE) begin
				timer_load <= 1'b1;
				timer_load_val <= {mem_rd_data, lo_byte};
			end else begin
				acc <= lo_byte;
				flags <= mem_rd_data[3:0];
			end
			busy <= 1'b0;
			op_done <= 1'b1;
			state <= ST_IDLE;
		end
		ST_READ_ONE: begin
			if (op == `DTX_OP_EXCHANGE) begin
				acc <= mem_rd_data;
				mem_addr <= base;
				mem_wr_data <= acc;
				mem_wr_en <= 1'b1;
				busy <= 1'b0;
				op_done <= 1'b1;
				state <= ST_IDLE;
			end else if (op == `DTX_OP_IND_STORE) begin
				mem_addr <= mem_rd_data;
				mem_wr_data <= acc;
				mem_wr_en <= 1'b1;
				busy <= 1'b0;
				op_done <= 1'b1;
				state <= ST_IDLE;
			end else begin
				mem_addr <= mem_rd_data;
				mem_rd_en <= 1'b1;
				state <= ST_READ_LAST;
			end
		end
		ST_READ_LAST: begin
			acc <= mem_rd_data;
			busy <= 1'b0;
			op_done <= 1'b1;
			state <= ST_IDLE;
		end
		default: begin
			busy <= 1'b0;
			state <= ST_IDLE;
		end
		endcase
	end
end

endmodule // dtx_exec_unit

// *** testbench/dtx_exec_chk.sv ***
// Checker for the data transfer execution unit
`timescale 1ns/1ps
module dtx_exec_chk (
	input logic core_clk,
	input logic rst,
	input logic op_valid,
	input logic [2:0] op_code,
	input logic [7:0] op_addr,
	input logic busy,
	input logic op_done,
	input logic [7:0] acc,
	input logic [3:0] flags,
	input logic [7:0] sp,
	input logic [7:0] mem_addr,
	input logic mem_wr_en,
	input logic [7:0] mem_wr_data,
	input logic mem_rd_en,
	input logic [15:0] timer_count,
	input logic timer_load
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire tk = op_valid && !busy;
	tmr_read_a: assert property (tk && op_code == 3'h0 |-> ##1
		mem_wr_en && mem_addr == $past(op_addr) ##1 mem_wr_en && op_done &&
		{mem_wr_data, $past(mem_wr_data)} == $past(timer_count, 2))
		else $error("timer read word wrong");
	tmr_write_a: assert property (tk && op_code == 3'h1 |-> ##1
		mem_rd_en ##2 timer_load && op_done) else $error("timer load late");
	xch_swap_a: assert property (tk && op_code == 3'h2 |-> ##2 op_done &&
		mem_wr_en && mem_wr_data == $past(acc, 2) && flags == $past(flags, 2))
		else $error("exchange wrong");
	pop_sp_a: assert property (tk && op_code == 3'h3 |-> ##1 mem_rd_en &&
		mem_addr == sp - 8'h02 ##1 sp == $past(sp) - 8'h02)
		else $error("pop pointer");
	push_sp_a: assert property (tk && op_code == 3'h4 |-> ##1 mem_wr_en &&
		mem_wr_data == $past(acc) && mem_addr == $past(sp) ##2
		sp == $past(sp, 3) + 8'h02) else $error("push wrong");
	ind_store_a: assert property (tk && op_code == 3'h5 |-> ##1 mem_rd_en
		##1 op_done && mem_wr_en && mem_wr_data == $past(acc, 2))
		else $error("indirect store wrong");
	ind_load_a: assert property (tk && op_code == 3'h6 |-> ##2 mem_rd_en
		##1 op_done && flags == $past(flags, 3)) else $error("indirect load");
	stack_image_a: assert property (tk && op_code == 3'h4 |-> ##2
		mem_wr_en && mem_wr_data == {4'h0, $past(flags, 2)})
		else $error("flag byte wrong");
endmodule // dtx_exec_chk
bind dtx_exec_unit dtx_exec_chk chk_u (.core_clk, .rst, .op_valid, .op_code,
	.op_addr, .busy, .op_done, .acc, .flags, .sp, .mem_addr, .mem_wr_en,
	.mem_wr_data, .mem_rd_en, .timer_count, .timer_load);

// *** testbench/dtx_mem_model.sv ***
// Data memory and timer model beside the unit
`timescale 1ns/1ps
module dtx_mem_model (
	input wire core_clk,
	input wire [7:0] mem_addr,
	input wire mem_wr_en,
	input wire [7:0] mem_wr_data,
	input wire mem_rd_en,
	output logic [7:0] mem_rd_data,
	input wire timer_load,
	input wire [15:0] timer_load_val,
	output logic [15:0] timer_count = 16'h0000
);
	logic [7:0] ram [0:255];
	// Read data stands while the strobe does, inverted otherwise
	assign mem_rd_data = mem_rd_en ? ram[mem_addr] : ~ram[mem_addr];
	always @(posedge core_clk) begin
		if (mem_wr_en)
			ram[mem_addr] <= mem_wr_data;
		timer_count <= timer_load ? timer_load_val : timer_count + 16'h0001;
	end
endmodule // dtx_mem_model

// *** testbench/testbench.sv ***
// Self-checking bench for the data transfer execution unit
`timescale 1ns/1ps
module testbench;
	logic core_clk = 0, rst = 1, op_valid = 0, ext_acc_wr = 0;
	logic ext_flag_wr = 0, ext_sp_wr = 0, busy, op_done, mem_wr_en;
	logic mem_rd_en, timer_load;
	logic [2:0] op_code = 3'h7;
	logic [3:0] ext_flag_val = 4'h0, flags;
	logic [7:0] op_addr = 8'h00, ext_acc_val = 8'h00, ext_sp_val = 8'h00;
	logic [7:0] acc, sp, mem_addr, mem_wr_data, mem_rd_data;
	logic [15:0] timer_count, timer_load_val, cap;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	dtx_exec_unit dut_u (.*);
	dtx_mem_model mem_u (.*);
	always #20 core_clk = ~core_clk;
	task close_out;
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task setr(input [7:0] a, input [3:0] f, input [7:0] s);
		{ext_acc_val, ext_flag_val, ext_sp_val} = {a, f, s};
		{ext_acc_wr, ext_flag_wr, ext_sp_wr} = 3'h7;
		@(posedge core_clk) #1 {ext_acc_wr, ext_flag_wr, ext_sp_wr} = 3'h0;
	endtask
	task do_op(input [2:0] c, input [7:0] a);
		int n;
		{op_code, op_addr, op_valid} = {c, a, 1'b1};
		cap = timer_count;
		@(posedge core_clk) #1 op_valid = 0;
		for (n = 0; n < 9 && op_done !== 1'b1; n++)
			@(posedge core_clk) #1;
		@(posedge core_clk) #1;
	endtask
	task t_timer;
		mem_u.ram[8'h10] = 8'h34;
		mem_u.ram[8'h11] = 8'h12;
		setr(8'h3c, 4'ha, 8'h00);
		do_op(3'h1, 8'h10);
		chk("tload", 16'h1234, timer_load_val);
		chk("tcnt", 16'h1234, timer_count);
		chk("tflg2", 16'ha3c, {flags, acc});
		do_op(3'h0, 8'h20);
		chk("tword", cap, {mem_u.ram[8'h21], mem_u.ram[8'h20]});
		chk("tflg1", 16'ha3c, {flags, acc});
	endtask
	task t_xch;
		setr(8'ha5, 4'h9, 8'h00);
		mem_u.ram[8'h30] = 8'h5a;
		do_op(3'h2, 8'h30);
		chk("xch", 16'h95a, {flags, acc});
		chk("xmem", 8'ha5, mem_u.ram[8'h30]);
	endtask
	task t_stack;
		setr(8'hc3, 4'h6, 8'hfe);
		do_op(3'h4, 8'h00);
		chk("psp", 8'h00, sp);
		chk("pflg", 16'h6c3, {flags, acc});
		chk("pimg", 16'h06c3, {mem_u.ram[8'hff], mem_u.ram[8'hfe]});
		setr(8'h00, 4'h0, 8'h00);
		do_op(3'h3, 8'h00);
		chk("pop", 16'h6c3, {flags, acc});
		chk("psp2", 8'hfe, sp);
	endtask
	task t_ind;
		mem_u.ram[8'h50] = 8'h60;
		mem_u.ram[8'h52] = 8'h61;
		mem_u.ram[8'h61] = 8'h88;
		setr(8'h77, 4'hb, 8'h00);
		do_op(3'h5, 8'h50);
		chk("istr", 8'h77, mem_u.ram[8'h60]);
		chk("iflg", 16'hb77, {flags, acc});
		do_op(3'h6, 8'h52);
		chk("ild", 16'hb88, {flags, acc});
	endtask
	// Pop taken in the very cycle that a push completes
	task t_b2b;
		setr(8'h5e, 4'hd, 8'h40);
		{op_code, op_addr, op_valid} = {3'h4, 8'h00, 1'b1};
		@(posedge core_clk) #1 op_code = 3'h3;
		@(posedge core_clk) #1;
		do_op(3'h3, 8'h00);
		chk("bimg", 16'h0d5e, {mem_u.ram[8'h41], mem_u.ram[8'h40]});
		chk("bpop", 16'hd5e, {flags, acc});
		chk("bsp", 8'h40, sp);
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			close_out;
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		#1 rst = 0;
		t_timer;
		t_xch;
		t_stack;
		t_ind;
		t_b2b;
		close_out;
	end
endmodule // testbench
